// ===== rtl/burst_sram_defs.vh
// Constants for the flow-through burst SRAM pin control block
`ifndef BURST_SRAM_DEFS_VH
`define BURST_SRAM_DEFS_VH
`define ADDR_WIDTH     10
`define DATA_WIDTH     32
`define LANES          4
`define LANE_WIDTH     8
`define BURST_LSB      0
`define BURST_MSB      1
`define BURST_LEN      4
`define MODE_LINEAR    1'b0
`define MODE_INTERLEAV 1'b1
`endif

// ===== rtl/burst_sram_ctrl.v
// Flow-through burst SRAM with load/advance burst counter and output masking
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`include "burst_sram_defs.vh"

// Function
// - Advance-or-load high on a recognized edge steps the burst counter during a read or write burst; deselected, it holds.
// - Advance-or-load low on a recognized edge loads a new address.
// - Synchronous inputs are captured only when the clock qualifier is low.
// - Clock qualifier high freezes all state but the output enables, which follow the pin, and the sleep status; it is not a deselect.
// - First select, active low, is sampled and combined with the other two.
// - Output enable low lets data and parity drive; high tri-states them.
// - Outputs masked in write data phase, first cycle after deselect, deselect.
// - Sleep input high enters low-power sleep, contents kept.
// - Data lines are captured on the rising edge for the write.
// - A read drives the contents of the location addressed in that cycle.
// - Parity lines act like data; each written only with its byte select.
// - Burst-order strap low gives linear, high gives interleaved order.
// - Low two address bits seed the two-bit burst counter.
// - Each active-low byte select, with write strobe, writes its own lane.
module burst_sram_ctrl (
    // Clock, reset, enable
    input  wire                        clk,
    input  wire                        reset,
    input  wire                        clkEnable,
    // Control pins
    input  wire                        clockQualifier_n,
    input  wire                        advanceOrLoad,
    input  wire                        writeStrobe_n,
    input  wire [`LANES-1:0]           byteLaneWrite_n,
    input  wire                        selectFirst_n,
    input  wire                        selectSecond,
    input  wire                        selectThird_n,
    input  wire                        outputDrive_n,
    input  wire                        sleepRequest,
    input  wire                        burstOrder,
    // Address pins
    input  wire [`ADDR_WIDTH-1:0]      address,
    // Data and parity lanes
    input  wire [`DATA_WIDTH-1:0]      dataIn,
    output reg  [`DATA_WIDTH-1:0]      dataOut,
    output reg  [`DATA_WIDTH-1:0]      dataOe,
    input  wire [`LANES-1:0]           parityIn,
    output reg  [`LANES-1:0]           parityOut,
    output reg  [`LANES-1:0]           parityOe,
    // Status
    output reg                         sleeping
);

    localparam ST_IDLE  = 3'b001;
    localparam ST_READ  = 3'b010;
    localparam ST_WRITE = 3'b100;
    localparam WL = `LANE_WIDTH + 1;

    // Pin synchronisers
    reg  [11:0]              syncA_reg;
    reg  [11:0]              syncB_reg;
    reg  [`ADDR_WIDTH-1:0]   addrA_reg;
    reg  [`ADDR_WIDTH-1:0]   addrB_reg;
    reg  [`DATA_WIDTH-1:0]   dataA_reg;
    reg  [`DATA_WIDTH-1:0]   dataB_reg;
    reg  [`LANES-1:0]        parA_reg;
    reg  [`LANES-1:0]        parB_reg;

    wire [11:0] pinsNow = {burstOrder, sleepRequest, outputDrive_n, selectThird_n,
                           selectSecond, selectFirst_n, byteLaneWrite_n,
                           writeStrobe_n, advanceOrLoad};

    // Control pins; reset value leaves the part deselected
    always @(posedge clk) begin
        if (reset) begin
            syncA_reg <= 12'h0ff;
            syncB_reg <= 12'h0ff;
        end else if (clkEnable) begin
            syncA_reg <= pinsNow;
            syncB_reg <= syncA_reg;
        end
    end

    // Address pins
    always @(posedge clk) begin
        if (reset) begin
            addrA_reg <= {`ADDR_WIDTH{1'b0}};
            addrB_reg <= {`ADDR_WIDTH{1'b0}};
        end else if (clkEnable) begin
            addrA_reg <= address;
            addrB_reg <= addrA_reg;
        end
    end

    // Data lines
    always @(posedge clk) begin
        if (reset) begin
            dataA_reg <= {`DATA_WIDTH{1'b0}};
            dataB_reg <= {`DATA_WIDTH{1'b0}};
        end else if (clkEnable) begin
            dataA_reg <= dataIn;
            dataB_reg <= dataA_reg;
        end
    end

    // Parity lines
    always @(posedge clk) begin
        if (reset) begin
            parA_reg <= {`LANES{1'b0}};
            parB_reg <= {`LANES{1'b0}};
        end else if (clkEnable) begin
            parA_reg <= parityIn;
            parB_reg <= parA_reg;
        end
    end

    reg  qualN_reg;
    always @(posedge clk) begin
        if (reset)
            qualN_reg <= 1'b1;
        else if (clkEnable)
            qualN_reg <= clockQualifier_n;
    end
    reg  qualNB_reg;
    always @(posedge clk) begin
        if (reset)
            qualNB_reg <= 1'b1;
        else if (clkEnable)
            qualNB_reg <= qualN_reg;
    end

    wire                advS     = syncB_reg[0];
    wire                weS_n    = syncB_reg[1];
    wire [`LANES-1:0]   bwS_n    = syncB_reg[5:2];
    wire                cs1S_n   = syncB_reg[6];
    wire                cs2S     = syncB_reg[7];
    wire                cs3S_n   = syncB_reg[8];
    wire                oeS_n    = syncB_reg[9];
    wire                sleepS   = syncB_reg[10];
    wire                orderS   = syncB_reg[11];
    wire                edgeOk   = clkEnable & ~qualNB_reg & ~sleepS;
    wire                selected = ~cs1S_n & cs2S & ~cs3S_n;

    // Storage
    reg  [WL*`LANES-1:0] mem [0:(1<<`ADDR_WIDTH)-1];

    reg  [2:0]              state_reg;
    reg  [2:0]              state_next;
    reg  [`ADDR_WIDTH-1:0]  base_reg;
    reg  [1:0]              count_reg;
    reg  [1:0]              seed_reg;
    reg                     order_reg;
    reg                     driveArm_reg;
    reg  [`ADDR_WIDTH-1:0]  accAddr;
    reg  [1:0]              burstLow;
    reg  [1:0]              countNext;

    // Burst address from counter and strap
    always @* begin
        countNext = count_reg + 2'h1;
        if (order_reg == `MODE_LINEAR)
            burstLow = seed_reg + countNext;
        else
            burstLow = seed_reg ^ countNext;
        if (!advS) begin
            accAddr = addrB_reg;
        end else begin
            accAddr = {base_reg[`ADDR_WIDTH-1:`BURST_MSB+1], burstLow};
        end
    end

    // Operation state
    always @* begin
        state_next = state_reg;
        if (!advS) begin
            if (!selected)
                state_next = ST_IDLE;
            else if (weS_n)
                state_next = ST_READ;
            else
                state_next = ST_WRITE;
        end else begin
            case (state_reg)
                ST_IDLE:  state_next = ST_IDLE;
                ST_READ:  state_next = ST_READ;
                ST_WRITE: state_next = ST_WRITE;
                default:  state_next = ST_IDLE;
            endcase
        end
    end

    // State register
    always @(posedge clk) begin
        if (reset) begin
            state_reg <= ST_IDLE;
        end else if (edgeOk) begin
            state_reg <= state_next;
        end
    end

    // Burst base, seed, counter and order
    always @(posedge clk) begin
        if (reset) begin
            base_reg  <= {`ADDR_WIDTH{1'b0}};
            count_reg <= 2'h0;
            seed_reg  <= 2'h0;
            order_reg <= `MODE_INTERLEAV;
        end else if (edgeOk) begin
            if (!advS) begin
                base_reg  <= addrB_reg;
                seed_reg  <= addrB_reg[`BURST_MSB:`BURST_LSB];
                count_reg <= 2'h0;
                order_reg <= orderS;
            end else if (state_reg != ST_IDLE) begin
                count_reg <= countNext;
            end
        end
    end

    // Read word at the access address
    reg  [WL*`LANES-1:0]   word;
    reg  [`DATA_WIDTH-1:0] rdData;
    reg  [`LANES-1:0]      rdPar;
    integer i;
    always @* begin
        word = mem[accAddr];
        for (i = 0; i < `LANES; i = i + 1) begin
            rdData[i*`LANE_WIDTH +: `LANE_WIDTH] = word[i*WL +: `LANE_WIDTH];
            rdPar[i] = word[i*WL + `LANE_WIDTH];
        end
    end

    // Merge written lanes into the stored word
    wire [WL*`LANES-1:0] wrWord;
    wire                 wrAny  = ~&bwS_n;
    wire                 wrTake = edgeOk && (state_next == ST_WRITE) && !weS_n;
    genvar g;
    generate
        for (g = 0; g < `LANES; g = g + 1) begin : laneWrite
            assign wrWord[g*WL +: WL] = bwS_n[g] ? word[g*WL +: WL] :
                {parB_reg[g], dataB_reg[g*`LANE_WIDTH +: `LANE_WIDTH]};
        end
    endgenerate

    // One write port for the whole word
    always @(posedge clk) begin
        if (wrTake && wrAny)
            mem[accAddr] <= wrWord;
    end

    // Drive permission: a read that is not the first after deselect
    wire armNext   = (state_next == ST_READ) && (state_reg != ST_IDLE);
    wire driveNext = armNext && ~oeS_n;

    // Permission held through a masked clock
    always @(posedge clk) begin
        if (reset)
            driveArm_reg <= 1'b0;
        else if (edgeOk)
            driveArm_reg <= armNext;
    end

    // Sleep status
    always @(posedge clk) begin
        if (reset)
            sleeping <= 1'b0;
        else if (clkEnable)
            sleeping <= sleepS;
    end

    // Read data on a recognized edge
    always @(posedge clk) begin
        if (reset) begin
            dataOut   <= {`DATA_WIDTH{1'b0}};
            parityOut <= {`LANES{1'b0}};
        end else if (edgeOk) begin
            dataOut   <= rdData;
            parityOut <= rdPar;
        end
    end

    // Output enables; the pin enable still acts while the clock is masked
    always @(posedge clk) begin
        if (reset) begin
            dataOe   <= {`DATA_WIDTH{1'b0}};
            parityOe <= {`LANES{1'b0}};
        end else if (clkEnable) begin
            if (sleepS) begin
                dataOe   <= {`DATA_WIDTH{1'b0}};
                parityOe <= {`LANES{1'b0}};
            end else if (edgeOk) begin
                dataOe   <= {`DATA_WIDTH{driveNext}};
                parityOe <= {`LANES{driveNext}};
            end else begin
                dataOe   <= {`DATA_WIDTH{~oeS_n & driveArm_reg}};
                parityOe <= {`LANES{~oeS_n & driveArm_reg}};
            end
        end
    end

endmodule

// ===== bench/sram_controller_model.sv
// Memory controller model that drives the SRAM pins
`timescale 1ns/1ns
module sram_controller_model (
    // Clock
    input  wire        clk,
    // Control, select and address pins
    output reg         clockQualifier_n = 1'b0,
    output reg         advanceOrLoad = 1'b0,
    output reg         writeStrobe_n = 1'b1,
    output reg  [3:0]  byteLaneWrite_n = 4'hf,
    output reg  [2:0]  selects = 3'b101,
    output reg  [9:0]  address = 10'h000,
    // Data and parity put on the lines
    output reg  [35:0] ctlData = 36'h0
);
    reg wasWrite = 1'b0;
    // One access; released lines keep a just-written value, else show the inverse of their last value
    task acc(input adv, input wn, input [3:0] bw, input [2:0] sel, input [9:0] a,
             input [35:0] d);
        @(posedge clk);
        clockQualifier_n <= 1'b0;
        advanceOrLoad <= adv;
        writeStrobe_n <= wn;
        byteLaneWrite_n <= bw;
        selects <= sel;
        address <= a;
        ctlData <= !wn ? d : (wasWrite ? ctlData : ~ctlData);
        wasWrite <= !wn;
    endtask
    // Qualifier high stretches the current cycle
    task stall(input integer n);
        repeat (n) @(posedge clk) clockQualifier_n <= 1'b1;
    endtask
endmodule

// ===== bench/burst_sram_properties.sv
// Port assertions for the burst SRAM pin control block
`timescale 1ns/1ns
`include "burst_sram_defs.vh"
module burst_sram_properties (
    // Clock and control pins
    input wire                   clk, reset, clkEnable, clockQualifier_n, advanceOrLoad,
    input wire                   writeStrobe_n, selectFirst_n, selectSecond, selectThird_n,
    input wire                   outputDrive_n, sleepRequest, sleeping,
    // Drive enables and read data
    input wire [`DATA_WIDTH-1:0] dataOut, dataOe,
    input wire [`LANES-1:0]      parityOe
);
    wire sel = !selectFirst_n && selectSecond && !selectThird_n;
    wire go  = !clockQualifier_n && clkEnable && !sleepRequest;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    write_tristate_a: assert property (go && sel && !advanceOrLoad && !writeStrobe_n
        |-> ##3 dataOe == 0) else $error("drive in write");
    deselect_tristate_a: assert property (go && !sel && !advanceOrLoad
        |-> ##3 dataOe == 0) else $error("drive when deselected");
    first_read_masked_a: assert property (go && !sel && !advanceOrLoad
        ##1 go && sel && !advanceOrLoad && writeStrobe_n |-> ##3 dataOe == 0)
        else $error("drive after deselect");
    enable_masked_a: assert property (outputDrive_n [*5] |-> dataOe == 0)
        else $error("drive with enable high");
    sleep_flag_a: assert property ((sleepRequest && clkEnable) [*5] |-> sleeping)
        else $error("sleep not entered");
    parity_follows_a: assert property (parityOe == {`LANES{dataOe[0]}}
        && (dataOe == 0 || &dataOe)) else $error("lane enables differ");
    freeze_hold_a: assert property (!clkEnable |=> $stable(dataOe) && $stable(dataOut))
        else $error("state moved in freeze");
    qualifier_hold_a: assert property (clockQualifier_n [*3]
        |=> $stable(dataOe) && $stable(dataOut)) else $error("edge not ignored");
    cover property (go && sel && advanceOrLoad && writeStrobe_n);
    cover property (sleeping);
    cover property (dataOe[0] ##1 dataOe[0]);
endmodule
bind burst_sram_ctrl burst_sram_properties props_inst (.clk, .reset, .clkEnable,
    .clockQualifier_n, .advanceOrLoad, .writeStrobe_n, .selectFirst_n, .selectSecond,
    .selectThird_n, .outputDrive_n, .sleepRequest, .sleeping, .dataOut, .dataOe, .parityOe);

// ===== bench/test_burst_sram_ctrl.sv
// Self-checking bench for the burst SRAM pin control block
`timescale 1ns/1ns
`include "burst_sram_defs.vh"
module test_burst_sram_ctrl;
    reg         clk = 1'b0, reset = 1'b1, clkEnable = 1'b1, outputDrive_n = 1'b0;
    reg         sleepRequest = 1'b0, burstOrder = 1'b0, ord = 1'b0, act = 1'b0, prevAct;
    reg  [31:0] seed = 32'hd549;
    reg  [35:0] mem [0:1023];
    reg  [35:0] q [$];
    reg  [9:0]  base = 10'h000;
    reg  [1:0]  k = 2'd0;
    integer     n_errors = 0, n_tests = 0, i, j;
    wire        clockQualifier_n, advanceOrLoad, writeStrobe_n, sleeping;
    wire [3:0]  byteLaneWrite_n, parityOut, parityOe;
    wire [2:0]  selects;
    wire [9:0]  address;
    wire [35:0] ctlData;
    wire [31:0] dataOut, dataOe;
    localparam  SEL = 3'b010;
    always #50 clk = ~clk;
    sram_controller_model ctl (.clk, .clockQualifier_n, .advanceOrLoad, .writeStrobe_n,
        .byteLaneWrite_n, .selects, .address, .ctlData);
    burst_sram_ctrl burst_sram_ctrl_inst (.clk, .reset, .clkEnable, .clockQualifier_n,
        .advanceOrLoad, .writeStrobe_n, .byteLaneWrite_n, .selectFirst_n(selects[2]),
        .selectSecond(selects[1]), .selectThird_n(selects[0]), .outputDrive_n,
        .sleepRequest, .burstOrder, .address, .dataOut, .dataOe, .parityOut, .parityOe,
        .dataIn((dataOe & dataOut) | (~dataOe & ctlData[31:0])), .sleeping,
        .parityIn((parityOe & parityOut) | (~parityOe & ctlData[35:32])));
    function automatic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        rnd = seed;
    endfunction
    // One access with its expected effect on memory and read data
    task op(input adv, input wn, input [3:0] bw, input [2:0] sel, input [9:0] a);
        reg [35:0] d;
        reg [9:0]  ea;
        integer    g;
        d[31:0] = rnd();
        d[35:32] = seed[7:4];
        ctl.acc(adv, wn, bw, sel, a, d);
        prevAct = act;
        if (!adv) begin
            {base, k, ord, act} = {a, 2'd0, burstOrder, sel == SEL};
        end else k = k + 2'd1;
        ea = {base[9:2], ord ? base[1:0] ^ k : base[1:0] + k};
        for (g = 0; g < 4; g = g + 1) if (act && !wn && !bw[g]) begin
            {mem[ea][32+g], mem[ea][8*g +: 8]} = {d[32+g], d[8*g +: 8]};
        end
        if (act && prevAct && wn && !outputDrive_n) q.push_back(mem[ea]);
    endtask
    task idle;
        op(1'b0, 1'b1, 4'hf, 3'b101, 10'h000);
        repeat (4) @(posedge clk);
    endtask
    task finish_test;
        if (n_errors == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(negedge clk) if (dataOe[0] === 1'b1) begin
        n_tests = n_tests + 1;
        if ({parityOut, dataOut} !== q[0]) begin
            n_errors = n_errors + 1;
            $display("[FAIL] %0t exp %h got %h", $time, q[0], {parityOut, dataOut});
        end
        if (q.size() > 0) q.delete(0);
    end
    initial begin
        #400000 n_errors = n_errors + 1;
        finish_test();
    end
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        for (i = 0; i < 8; i = i + 1) begin
            burstOrder <= i[2];
            for (j = 0; j < 4; j = j + 1) begin
                op(j != 0, 1'b0, 4'h0, SEL, {5'h0, i[2:0], i[1:0]});
                if (i == 3 && j == 1) ctl.stall(3);
            end
        end
        for (i = 0; i < 8; i = i + 1) begin
            idle();
            outputDrive_n <= (i == 6);
            if (i == 2) clkEnable <= 1'b0;
            if (i == 2) repeat (3) @(posedge clk);
            clkEnable <= 1'b1;
            for (j = 0; j < 5; j = j + 1) op(j % 4 != 0, 1'b1, 4'hf, SEL, {5'h0, i[2:0], i[1:0]});
        end
        for (i = 0; i < 8; i = i + 1) begin
            idle();
            op(1'b0, 1'b1, 4'hf, i[2:0], 10'h005);
            op(1'b0, 1'b1, 4'hf, SEL, 10'h005);
        end
        idle();
        op(1'b0, 1'b0, 4'h0, SEL, 10'h200);
        op(1'b0, 1'b0, 4'ha, SEL, 10'h200);
        for (j = 0; j < 2; j = j + 1) op(1'b0, 1'b1, 4'hf, SEL, 10'h200);
        idle();
        sleepRequest <= 1'b1;
        repeat (8) @(posedge clk);
        sleepRequest <= 1'b0;
        repeat (4) @(posedge clk);
        op(1'b1, 1'b1, 4'hf, SEL, 10'h000);
        for (j = 1; j < 3; j = j + 1) op(1'b0, 1'b1, 4'hf, SEL, j[9:0]);
        idle();
        if (q.size() != 0) begin
            n_errors = n_errors + 1;
            $display("[FAIL] %0t exp %h got %h", $time, 0, q.size());
        end
        finish_test();
    end
endmodule
